// ===== hw/spm_pin_mux.sv
// Purpose: routes internal status to the general output pins and
//          drives them and the serial readback pin
// Assumes: APB slave on pclk; status inputs synchronous to pclk
// Notes:   pin levels and APB outputs are all registered
`include "spm_params.svh"

module spm_pin_mux #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spm_pkg::spm_status_s status_in,
    output spm_pkg::spm_pins_s general_output_pin,
    output logic serial_readback_pin_o,
    output logic serial_readback_pin_oe,
    output logic irq
);

    localparam int N = spm_pkg::NUM_OUT;

    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 10 and 32");
        end
    end

    spm_pkg::spm_state_s st;
    spm_pkg::spm_state_s next_st;

    function automatic logic [ADDR_W-1:0] byte_addr(
        input logic [7:0] idx
    );
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // level of the internal signal chosen by one selection code
    function automatic logic sel_level(
        input logic [5:0] code,
        input spm_pkg::spm_status_s s
    );
        logic [5:0] off;
        off = 6'h00;
        sel_level = 1'b0;
        if (code == `SPM_SEL_ALARM) begin
            sel_level = s.alarm;
        end else if (code == `SPM_SEL_SPI_SDO) begin
            sel_level = s.spi_read_data;
        end else if (code >= `SPM_SEL_MISC_LO &&
                     code <= `SPM_SEL_MISC_HI) begin
            off = code - `SPM_SEL_MISC_LO;
            sel_level = s.misc[off[4:0]];
        end else if (code == `SPM_SEL_EXIT_PH0) begin
            sel_level = s.exit_phase[0];
        end else if (code == `SPM_SEL_EXIT_PH1) begin
            sel_level = s.exit_phase[1];
        end else if (code == `SPM_SEL_CH_BUSY) begin
            sel_level = s.chan_busy;
        end else if (code >= `SPM_SEL_SYSREF_LO &&
                     code <= `SPM_SEL_SYSREF_HI) begin
            off = code - `SPM_SEL_SYSREF_LO;
            sel_level = s.sysref_state[off[1:0]];
        end else if (code == `SPM_SEL_FORCE_HI) begin
            sel_level = 1'b1;
        end else if (code == `SPM_SEL_FORCE_LO) begin
            sel_level = 1'b0;
        end else if (code >= `SPM_SEL_DAC_AVG_LO &&
                     code <= `SPM_SEL_DAC_AVG_HI) begin
            off = code - `SPM_SEL_DAC_AVG_LO;
            sel_level = s.dac_avg[off[1:0]];
        end else if (code >= `SPM_SEL_DAC_CUR_LO &&
                     code <= `SPM_SEL_DAC_CUR_HI) begin
            off = code - `SPM_SEL_DAC_CUR_LO;
            sel_level = s.dac_cur[off[1:0]];
        end else if (code == `SPM_SEL_HOLD_CMP) begin
            sel_level = s.hold_cmp;
        end else if (code == `SPM_SEL_PULSE_REQ) begin
            sel_level = s.pulse_req;
        end
    endfunction

    // open-drain only pulls low; push-pull drives both levels
    function automatic logic [1:0] drive(
        input logic on,
        input logic push_pull,
        input logic lvl
    );
        drive = {on && (push_pull || !lvl), on && push_pull && lvl};
    endfunction

    logic setup;
    logic access;
    logic is_wr;
    logic is_rd;
    logic hit_gpo;
    logic [1:0] gpo_idx;
    logic hit_rdbk;
    logic hit_stat;
    logic hit_mask;

    assign setup = psel && !penable;
    assign access = psel && penable && st.pready;
    assign is_wr = access && pwrite;
    assign is_rd = access && !pwrite;

    always_comb begin
        hit_gpo = 1'b0;
        gpo_idx = 2'd0;
        for (int i = 0; i < N; i++) begin
            if (paddr == byte_addr(`SPM_IDX_GPO0 + 8'(i))) begin
                hit_gpo = 1'b1;
                gpo_idx = 2'(i);
            end
        end
        hit_rdbk = paddr == byte_addr(`SPM_IDX_RDBK);
        hit_stat = paddr == byte_addr(`SPM_IDX_IRQ_STAT);
        hit_mask = paddr == byte_addr(`SPM_IDX_IRQ_MASK);
    end

    always_comb begin
        logic [1:0] drv;
        logic [5:0] code;
        drv = 2'b00;
        code = 6'h00;
        next_st = st;

        // registers take writes on the access edge only
        if (is_wr && pstrb[0]) begin
            if (hit_gpo) begin
                next_st.gpo_ctl[gpo_idx] = pwdata[7:0];
            end
            if (hit_rdbk) begin
                next_st.rdbk_ctl = pwdata[1:0];
            end
            if (hit_mask) begin
                next_st.irq_mask = pwdata[N-1:0];
            end
        end

        // reading status clears it; a fresh edge below still sets
        if (is_rd && hit_stat) begin
            next_st.irq_stat = '0;
        end

        for (int i = 0; i < N; i++) begin
            code = st.gpo_ctl[i][`SPM_FLD_SEL_HI:`SPM_FLD_SEL_LO];
            next_st.level[i] = sel_level(code, status_in);
            drv = drive(st.gpo_ctl[i][`SPM_FLD_ON],
                        st.gpo_ctl[i][`SPM_FLD_TYPE],
                        st.level[i]);
            next_st.pins.pin_oe[i] = drv[1];
            next_st.pins.pin_o[i] = drv[0];
            if (next_st.level[i] != st.level[i]) begin
                next_st.irq_stat[i] = 1'b1;
            end
        end

        drv = drive(st.rdbk_ctl[`SPM_FLD_ON],
                    st.rdbk_ctl[`SPM_FLD_TYPE],
                    status_in.spi_read_data);
        next_st.rdbk_oe = drv[1];
        next_st.rdbk_o = drv[0];

        next_st.irq = |(next_st.irq_stat & st.irq_mask);

        // one wait-free access: pready rises for the access phase
        next_st.pready = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (setup) begin
            next_st.pslverr = !(hit_gpo || hit_rdbk || hit_stat ||
                                hit_mask);
            if (!pwrite) begin
                if (hit_gpo) begin
                    next_st.prdata = {24'h00_0000, st.gpo_ctl[gpo_idx]};
                end else if (hit_rdbk) begin
                    next_st.prdata = {30'h0000_0000, st.rdbk_ctl};
                end else if (hit_stat) begin
                    next_st.prdata = {28'h000_0000, st.irq_stat};
                end else if (hit_mask) begin
                    next_st.prdata = {28'h000_0000, st.irq_mask};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.gpo_ctl <= {N{`SPM_RST_GPO}};
            st.rdbk_ctl <= `SPM_RST_RDBK;
            st.irq_stat <= '0;
            st.irq_mask <= `SPM_RST_MASK;
            st.level <= '0;
            st.pins <= '0;
            st.rdbk_o <= 1'b0;
            st.rdbk_oe <= 1'b0;
            st.irq <= 1'b0;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign general_output_pin = st.pins;
    assign serial_readback_pin_o = st.rdbk_o;
    assign serial_readback_pin_oe = st.rdbk_oe;
    assign irq = st.irq;

endmodule

// ===== hw/spm_params.svh
// Purpose: offsets, field positions, reset values and codes for the
//          status output pin mux
// Assumes: 32-bit APB, one register per aligned word
// Notes:   byte address is four times the register index
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_IDX_GPO0 8'h50
`define SPM_IDX_GPO1 8'h51
`define SPM_IDX_GPO2 8'h52
`define SPM_IDX_GPO3 8'h53
`define SPM_IDX_RDBK 8'h54
`define SPM_IDX_IRQ_STAT 8'h60
`define SPM_IDX_IRQ_MASK 8'h61

`define SPM_FLD_SEL_HI 7
`define SPM_FLD_SEL_LO 2
`define SPM_FLD_TYPE 1
`define SPM_FLD_ON 0

`define SPM_RST_GPO 8'h00
`define SPM_RST_RDBK 2'h0
`define SPM_RST_MASK 4'h0

`define SPM_SEL_ALARM 6'h00
`define SPM_SEL_SPI_SDO 6'h01
`define SPM_SEL_MISC_LO 6'h02
`define SPM_SEL_MISC_HI 6'h17
`define SPM_SEL_EXIT_PH0 6'h18
`define SPM_SEL_EXIT_PH1 6'h19
`define SPM_SEL_CH_BUSY 6'h1A
`define SPM_SEL_SYSREF_LO 6'h1B
`define SPM_SEL_SYSREF_HI 6'h1E
`define SPM_SEL_FORCE_HI 6'h1F
`define SPM_SEL_FORCE_LO 6'h20
`define SPM_SEL_DAC_AVG_LO 6'h27
`define SPM_SEL_DAC_AVG_HI 6'h2A
`define SPM_SEL_DAC_CUR_LO 6'h2B
`define SPM_SEL_DAC_CUR_HI 6'h2E
`define SPM_SEL_HOLD_CMP 6'h3D
`define SPM_SEL_PULSE_REQ 6'h3E

`endif

// ===== hw/spm_pkg.sv
// Purpose: types for the status output pin mux
// Assumes: four general output pins
// Notes:   NUM_OUT lives here; other constants live in spm_params.svh
package spm_pkg;

    localparam int NUM_OUT = 4;

    typedef struct packed {
        logic alarm;
        logic spi_read_data;
        logic [21:0] misc;
        logic [1:0] exit_phase;
        logic chan_busy;
        logic [3:0] sysref_state;
        logic [3:0] dac_avg;
        logic [3:0] dac_cur;
        logic hold_cmp;
        logic pulse_req;
    } spm_status_s;

    typedef struct packed {
        logic [NUM_OUT-1:0] pin_o;
        logic [NUM_OUT-1:0] pin_oe;
    } spm_pins_s;

    typedef struct packed {
        logic [NUM_OUT-1:0][7:0] gpo_ctl;
        logic [1:0] rdbk_ctl;
        logic [NUM_OUT-1:0] irq_stat;
        logic [NUM_OUT-1:0] irq_mask;
        logic [NUM_OUT-1:0] level;
        spm_pins_s pins;
        logic rdbk_o;
        logic rdbk_oe;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } spm_state_s;

endpackage

// ===== tb/spm_checker.sv
// Purpose: port checks for spm_pin_mux
// Assumes: one clock, async active-low reset
// Notes: gpo1 writes are decoded to follow forced levels
`include "spm_params.svh"
module spm_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire spm_pkg::spm_pins_s general_output_pin,
    input wire logic serial_readback_pin_o,
    input wire logic serial_readback_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr1;
    logic [7:0] d;
    logic [3:0] po;
    logic [3:0] pe;
    assign wr1 = psel && penable && pwrite && pready && pstrb[0]
        && paddr == ADDR_W'({`SPM_IDX_GPO1, 2'h0});
    assign d = pwdata[7:0];
    assign po = general_output_pin.pin_o;
    assign pe = general_output_pin.pin_oe;
    AST_FORCE_HI: assert property (
        wr1 && d == 8'h7F |-> ##3 po[1] && pe[1])
        else $error("forced high not driven");
    AST_FORCE_LO: assert property (
        wr1 && d == 8'h83 |-> ##3 !po[1] && pe[1])
        else $error("forced low not driven");
    AST_OD_RELEASE: assert property (
        wr1 && d == 8'h7D |-> ##3 !pe[1])
        else $error("open-drain high not released");
    AST_OFF: assert property (
        wr1 && !d[0] |-> ##2 !pe[1] && !po[1])
        else $error("disabled pin driven");
    AST_QUIET: assert property ((po & ~pe) == 4'h0)
        else $error("pin level without enable");
    AST_RDBK_QUIET: assert property (
        serial_readback_pin_o |-> serial_readback_pin_oe)
        else $error("readback level without enable");
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    cover property (wr1);
    cover property (pslverr);
    cover property (pe[1] && !po[1]);
endmodule
bind spm_pin_mux spm_checker #(.ADDR_W(ADDR_W)) u_spm_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_output_pin(general_output_pin),
    .serial_readback_pin_o(serial_readback_pin_o),
    .serial_readback_pin_oe(serial_readback_pin_oe));

// ===== tb/spm_board.sv
// Purpose: board side of the pins, with pull-ups
// Assumes: every pin has a pull-up resistor
// Notes: a released pin reads high
module spm_board (
    input wire spm_pkg::spm_pins_s pins,
    input wire logic rb_o,
    input wire logic rb_oe,
    output logic [3:0] pad,
    output logic rb_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad[i] = pins.pin_oe[i] ? pins.pin_o[i] : 1'b1;
        end
        rb_pad = rb_oe ? rb_o : 1'b1;
    end
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for spm_pin_mux
// Assumes: apb slave answers in its own time
// Notes: pin levels are seen through the board model in t_drive only
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    spm_pkg::spm_status_s st = '0;
    spm_pkg::spm_pins_s gp;
    logic rb_o;
    logic rb_oe;
    logic rb_pad;
    logic [3:0] pad;
    logic [31:0] r;
    logic e;
    int n_mismatch = 0;
    int comparisons = 0;
    initial begin
        forever #5 pclk = ~pclk;
    end
    spm_pin_mux #(.ADDR_W(12)) u_spm_pin_mux (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_in(st), .general_output_pin(gp),
        .serial_readback_pin_o(rb_o), .serial_readback_pin_oe(rb_oe),
        .irq(irq));
    spm_board u_spm_board (.pins(gp), .rb_o(rb_o), .rb_oe(rb_oe),
        .pad(pad), .rb_pad(rb_pad));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(r, x);
    endtask
    function automatic logic lvl(input logic [5:0] c,
        input spm_pkg::spm_status_s s);
        case (c) inside
            6'h00: return s.alarm;
            6'h01: return s.spi_read_data;
            [6'h02:6'h17]: return s.misc[c - 6'h02];
            [6'h18:6'h19]: return s.exit_phase[c - 6'h18];
            6'h1A: return s.chan_busy;
            [6'h1B:6'h1E]: return s.sysref_state[c - 6'h1B];
            6'h1F: return 1'b1;
            [6'h27:6'h2A]: return s.dac_avg[c - 6'h27];
            [6'h2B:6'h2E]: return s.dac_cur[c - 6'h2B];
            6'h3D: return s.hold_cmp;
            6'h3E: return s.pulse_req;
            default: return 1'b0;
        endcase
    endfunction
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            rd(12'h140 + 12'(4 * i), 32'h0);
        end
        rd(12'h184, 32'h0);
        chk({gp.pin_oe, rb_oe}, 32'h0);
    endtask
    task automatic t_route();
        logic [43:0] pat;
        logic [5:0] c;
        for (int p = 0; p < 3; p++) begin
            pat = p == 0 ? {22{2'h1}} : p == 1 ? {22{2'h2}} : {11{4'h3}};
            st <= spm_pkg::spm_status_s'(pat[40:0]);
            for (int i = 0; i < 64; i++) begin
                c = 6'(i);
                wr(12'h140 + {8'h0, c[1:0], 2'h0}, {26'h0, c, 2'h3});
                repeat (3) @(posedge pclk);
                chk(gp.pin_o[c[1:0]], lvl(c, st));
                chk(gp.pin_oe[c[1:0]], 32'h1);
            end
        end
    endtask
    task automatic t_drive();
        logic ox;
        logic ex;
        for (int l = 0; l < 2; l++) begin
            for (int m = 0; m < 4; m++) begin
                st.spi_read_data <= 1'(l);
                wr(12'h144, {24'h0, l ? 6'h1F : 6'h20, 2'(m)});
                wr(12'h150, 32'(m));
                repeat (3) @(posedge pclk);
                ex = m[0] & (m[1] | !l);
                ox = m[0] & m[1] & l[0];
                chk({pad[1], gp.pin_oe[1], gp.pin_o[1]},
                    {ex ? ox : 1'b1, ex, ox});
                chk({rb_pad, rb_oe, rb_o}, {ex ? ox : 1'b1, ex, ox});
            end
        end
    endtask
    task automatic t_regs();
        wr(12'h150, 32'hFF);
        rd(12'h150, 32'h3);
        wr(12'h14C, 32'h7F);
        apb(1'b1, 12'h14C, 32'h0, 4'h0);
        rd(12'h14C, 32'h7F);
        apb(1'b0, 12'h3FC, 32'h0, 4'hF);
        chk({e, r[30:0]}, 32'h80000000);
    endtask
    task automatic t_irq();
        wr(12'h148, 32'h83);
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h180, 32'h0, 4'hF);
        wr(12'h148, 32'h7F);
        repeat (3) @(posedge pclk);
        chk(irq, 32'h0);
        rd(12'h180, 32'h4);
        rd(12'h180, 32'h0);
        wr(12'h184, 32'h4);
        rd(12'h184, 32'h4);
        wr(12'h148, 32'h83);
        repeat (3) @(posedge pclk);
        chk(irq, 32'h1);
        rd(12'h180, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h0);
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_route();
        t_drive();
        t_regs();
        t_irq();
        close_out();
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule
